// ---- core/usb_event_consts.svh ----
// What this block does
// - remote wakeup completion sets flag bit 23
// - resume while suspended sets flag bit 22
// - entering suspend sets flag bit 21
// - bus reset resets core, sets bit 20
// - start-of-frame packet sets flag bit 19
// - NAK handshake sets flag bit 18
// - receive pipeline overflow sets flag bit 17
// - transmit pipeline underflow sets flag bit 16
// - receive buffer overflow sets flag bit 15
// - transmit buffer underflow sets flag bit 14
// - endpoint receive-valid rise sets bit 7+n
// - endpoint transmit-active fall sets bit n
// - enable bits 23..0 mask matching flags
// - flag register at its address, resets zero
// - enable register at its address, resets zero
`ifndef USB_EVENT_CONSTS_SVH
`define USB_EVENT_CONSTS_SVH

`define USB_EVENT_FLAGS_ADDR 32'h4000A888
`define USB_EVENT_ENABLES_ADDR 32'h4000A88C
`define USB_EVENT_CLEAR_ADDR 32'h4000A890
`define USB_EVENT_FLAGS_RESET 24'h000000
`define USB_EVENT_ENABLES_RESET 24'h000000

`define USB_EV_REMOTE_WAKE_DONE 23
`define USB_EV_BUS_RESUME_SEEN 22
`define USB_EV_SUSPEND_ENTERED 21
`define USB_EV_BUS_RESET_SEEN 20
`define USB_EV_FRAME_START_SEEN 19
`define USB_EV_NAK_SEEN 18
`define USB_EV_RX_PIPELINE_OVERFLOW 17
`define USB_EV_TX_PIPELINE_UNDERFLOW 16
`define USB_EV_RX_BUFFER_OVERFLOW 15
`define USB_EV_TX_BUFFER_UNDERFLOW 14
`define USB_EV_RX_VALID_BASE 7
`define USB_EV_TX_DONE_BASE 0

`endif

// ---- core/usb_event_flag_enable.sv ----
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "usb_event_consts.svh"

module usb_event_flag_enable
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic remote_wake_done,
    input wire logic bus_resume_seen,
    input wire logic suspended,
    input wire logic bus_reset_seen,
    input wire logic frame_start_seen,
    input wire logic nak_seen,
    input wire logic rx_pipeline_overflow,
    input wire logic tx_pipeline_underflow,
    input wire logic rx_buffer_overflow,
    input wire logic tx_buffer_underflow,
    input wire logic [13:0] ep_buffer_rx_valid,
    input wire logic [13:0] ep_buffer_tx_active,
    output logic core_reset,
    output logic irq
);

    usb_event_pkg::state_t state_r;
    usb_event_pkg::state_t state_nxt;

    logic [23:0] set_vec;
    logic [23:0] clr_vec;
    logic [13:0] rx_rise;
    logic [13:0] tx_fall;
    logic setup_phase;
    logic access_done;
    logic hit_flags;
    logic hit_enables;
    logic hit_clear;

    assign setup_phase = psel & ~penable;
    // writes take effect only on the completing access edge
    assign access_done = psel & penable & state_r.pready;
    assign hit_flags = (paddr == `USB_EVENT_FLAGS_ADDR);
    assign hit_enables = (paddr == `USB_EVENT_ENABLES_ADDR);
    assign hit_clear = (paddr == `USB_EVENT_CLEAR_ADDR);

    // each endpoint owns two buffer bits, 2n and 2n+1
    assign rx_rise = ep_buffer_rx_valid & ~state_r.rx_valid_prev;
    assign tx_fall = ~ep_buffer_tx_active & state_r.tx_active_prev;

    always_comb
    begin
        set_vec = 24'h000000;
        set_vec[`USB_EV_REMOTE_WAKE_DONE] = remote_wake_done;
        // a resume only counts while the core is in suspend
        set_vec[`USB_EV_BUS_RESUME_SEEN] = bus_resume_seen & suspended;
        set_vec[`USB_EV_SUSPEND_ENTERED] = suspended & ~state_r.suspended_prev;
        set_vec[`USB_EV_BUS_RESET_SEEN] = bus_reset_seen;
        set_vec[`USB_EV_FRAME_START_SEEN] = frame_start_seen;
        set_vec[`USB_EV_NAK_SEEN] = nak_seen;
        set_vec[`USB_EV_RX_PIPELINE_OVERFLOW] = rx_pipeline_overflow;
        set_vec[`USB_EV_TX_PIPELINE_UNDERFLOW] = tx_pipeline_underflow;
        set_vec[`USB_EV_RX_BUFFER_OVERFLOW] = rx_buffer_overflow;
        set_vec[`USB_EV_TX_BUFFER_UNDERFLOW] = tx_buffer_underflow;
        for (int n = 0; n < usb_event_pkg::NUM_EP; n++)
        begin
            set_vec[`USB_EV_RX_VALID_BASE + n] = rx_rise[2*n] | rx_rise[2*n+1];
            set_vec[`USB_EV_TX_DONE_BASE + n] = tx_fall[2*n] | tx_fall[2*n+1];
        end
    end

    always_comb
    begin
        clr_vec = 24'h000000;
        if (access_done && pwrite && (hit_flags || hit_clear))
        begin
            clr_vec = pwdata[23:0];
        end
    end

    always_comb
    begin
        state_nxt = state_r;
        state_nxt.rx_valid_prev = ep_buffer_rx_valid;
        state_nxt.tx_active_prev = ep_buffer_tx_active;
        state_nxt.suspended_prev = suspended;
        // an event in the clearing cycle survives the clear
        state_nxt.flags = (state_r.flags & ~clr_vec) | set_vec;
        if (access_done && pwrite && hit_enables)
        begin
            state_nxt.enables = pwdata[23:0];
        end
        state_nxt.core_reset = bus_reset_seen;
        state_nxt.pready = 1'b0;
        state_nxt.pslverr = 1'b0;
        if (setup_phase)
        begin
            // zero wait states: answer is ready in the first access cycle
            state_nxt.pready = 1'b1;
            state_nxt.pslverr = ~(hit_flags | hit_enables | hit_clear);
            state_nxt.prdata = 32'h00000000;
            if (!pwrite && hit_flags)
            begin
                state_nxt.prdata = {8'h00, state_r.flags};
            end
            else if (!pwrite && hit_enables)
            begin
                state_nxt.prdata = {8'h00, state_r.enables};
            end
        end
        else if (access_done)
        begin
            state_nxt.prdata = 32'h00000000;
        end
        state_nxt.irq = |(state_nxt.flags & state_nxt.enables);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r.flags <= `USB_EVENT_FLAGS_RESET;
            state_r.enables <= `USB_EVENT_ENABLES_RESET;
            state_r.rx_valid_prev <= 14'h0000;
            state_r.tx_active_prev <= 14'h0000;
            state_r.suspended_prev <= 1'b0;
            state_r.prdata <= 32'h00000000;
            state_r.pready <= 1'b0;
            state_r.pslverr <= 1'b0;
            state_r.irq <= 1'b0;
            state_r.core_reset <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign prdata = state_r.prdata;
    assign pready = state_r.pready;
    assign pslverr = state_r.pslverr;
    assign core_reset = state_r.core_reset;
    assign irq = state_r.irq;

endmodule : usb_event_flag_enable

// ---- core/usb_event_pkg.sv ----
package usb_event_pkg;

    localparam int unsigned NUM_EP = 7;
    localparam int unsigned EVENT_W = 24;

    typedef struct packed {
        logic [EVENT_W-1:0] flags;
        logic [EVENT_W-1:0] enables;
        logic [NUM_EP*2-1:0] rx_valid_prev;
        logic [NUM_EP*2-1:0] tx_active_prev;
        logic suspended_prev;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic core_reset;
    } state_t;

endpackage : usb_event_pkg

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, suspended = 0, pready, pslverr, core_reset, irq, er;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic [13:0] rxv = 0, txa = 0;
    logic [8:0] ev_req = 0, ev;
    int err_count = 0, n_tests = 0;
    localparam logic [31:0] fl_adr = 32'h4000A888, en_adr = 32'h4000A88C;
    always #10 clk = ~clk;
    usb_host_model u_host (.clk(clk), .ev_req(ev_req), .ev(ev));
    usb_event_flag_enable u_dut (.*, .remote_wake_done(ev[8]), .bus_resume_seen(ev[7]), .bus_reset_seen(ev[6]),
        .frame_start_seen(ev[5]), .nak_seen(ev[4]), .rx_pipeline_overflow(ev[3]), .tx_pipeline_underflow(ev[2]),
        .rx_buffer_overflow(ev[1]), .tx_buffer_underflow(ev[0]), .ep_buffer_rx_valid(rxv), .ep_buffer_tx_active(txa));
    task automatic test_done;
        $display("tests %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [31:0] a, d);
        int k;
        // let the release of the previous transfer take effect before the next setup
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1 && k < 9);
        if (k == 9)
        begin
            err_count++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // read flags, compare, then clear what was read
    task automatic rd_clr(input logic [31:0] exp);
        apb(0, fl_adr, 32'h0);
        chk(rd, exp);
        apb(1, fl_adr, rd);
    endtask : rd_clr
    task automatic pulse(input int i);
        ev_req <= 9'h001 << i;
        @(posedge clk);
        ev_req <= 9'h000;
        repeat (2) @(posedge clk);
    endtask : pulse
    task automatic t_reset;
        apb(0, fl_adr, 32'h0);
        chk(rd, 32'h0);
        apb(0, en_adr, 32'h0);
        chk(rd, 32'h0);
        apb(0, 32'h4000A8F0, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("t_reset end");
    endtask : t_reset
    task automatic t_events;
        apb(1, en_adr, 32'hFFFFFFFF);
        apb(0, en_adr, 32'h0);
        chk(rd, 32'h00FFFFFF);
        suspended <= 1;
        @(posedge clk);
        rd_clr(32'h00200000);
        for (int i = 0; i < 9; i++)
        begin
            pulse(i);
            rd_clr(32'h1 << (i > 6 ? 15 + i : 14 + i));
        end
        suspended <= 0;
        pulse(7);
        rd_clr(32'h0);
        $display("t_events end");
    endtask : t_events
    task automatic t_ep;
        txa <= 14'h3FFF;
        repeat (2) @(posedge clk);
        rd_clr(32'h0);
        for (int n = 0; n < 7; n++)
        begin
            rxv[2 * n + 1] <= 1;
            txa[2 * n] <= 0;
            repeat (2) @(posedge clk);
            rd_clr((32'h80 << n) | (32'h1 << n));
        end
        $display("t_ep end");
    endtask : t_ep
    task automatic t_mask;
        apb(1, en_adr, 32'h0);
        pulse(4);
        chk({31'h0, irq}, 32'h0);
        apb(1, en_adr, 32'h00040000);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        rd_clr(32'h00040000);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        $display("t_mask end");
    endtask : t_mask
    initial
    begin
        repeat (10) @(posedge clk);
        arst_n <= 1;
        t_reset();
        t_events();
        t_ep();
        t_mask();
        test_done();
    end
endmodule : tb_top

// ---- verif/usb_event_chk.sv ----
`timescale 1ns/1ps
module usb_event_chk (input wire logic clk, arst_n, psel, penable, pwrite, pready, pslverr, bus_reset_seen,
    input wire logic core_reset, irq, input wire logic [31:0] paddr, prdata);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic map_ok = paddr inside {32'h4000A888, 32'h4000A88C, 32'h4000A890};
    rdy_answer_a: assert property (psel && !penable |=> pready) else $error("no answer");
    rdy_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    err_unmapped_a: assert property (pready |-> pslverr == !map_ok) else $error("pslverr wrong");
    top_zero_a: assert property (pready && !pwrite |-> prdata[31:24] == 8'h00) else $error("top set");
    rd_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
    core_rst_a: assert property (bus_reset_seen |=> core_reset) else $error("no core reset");
    core_cause_a: assert property (core_reset |-> $past(bus_reset_seen)) else $error("stray reset");
    irq_fall_a: assert property ($fell(irq) |-> $past(pready && pwrite)) else $error("irq fell");
    cover property (pslverr);
    cover property ($rose(irq));
    cover property (core_reset);
endmodule : usb_event_chk
bind usb_event_flag_enable usb_event_chk u_chk (.*);

// ---- verif/usb_host_model.sv ----
`timescale 1ns/1ps
module usb_host_model (input wire logic clk, input wire logic [8:0] ev_req, output logic [8:0] ev = 9'h000);
    // the bus side never holds an event: a request longer than one cycle yields a pulse on every other cycle
    // remote wake done stands for the end of a software resume request made outside this block
    always @(posedge clk)
    begin
        ev <= ev_req & ~ev;
    end
endmodule : usb_host_model
